// >>> rtl/led_clock_output_sel.sv
`timescale 1ns/1ps
`default_nettype none
module led_clock_output_sel
   import pin_mux_pkg::*;
(
   input wire logic [2:0] sel,
   input wire logic func_level,
   input wire logic compl_level,
   input wire pin_sources_t src,
   output logic level
);
   // ==========================================================
   // indicator selector decode, shared by both indicator pins
   always_comb begin
      case (sel)
         LSEL_FUNC: level = func_level;
         LSEL_MATCH: level = src.data_match;
         LSEL_UVOLT: level = src.under_voltage;
         LSEL_INTR: level = src.interrupt;
         LSEL_COMPL: level = compl_level;
         LSEL_LOW: level = 1'b0;
         LSEL_HIGH: level = 1'b1;
         default: level = 1'b0; // reserved code held inactive
      endcase
   end
endmodule // led_clock_output_sel
`default_nettype wire

// >>> rtl/led_clock_pin_mux.sv
// Behaviour
// - second indicator pin follows 3-bit selector at bits 10-8; 001b reserved.
// - first indicator pin follows selector at bits 2-0; 101b shows compliance pick.
// - default functions: pin two link up blinking on activity, pin one link.
// - bits 5-3 pick clock: 000b crystal 25MHz, 011b/100b the 125MHz clock.
// - clock pin selector resets to 1 (clock); 100b-110b low, 111b high.
// - test mode with direction value zero drives each pad from force bit.
// - override bit enters pad test mode using direction bit and force levels.
// - compliance selector picks one of six compliance signals, 000b to 101b.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module led_clock_pin_mux
   import pin_mux_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pin_sources_t src_async,
   input wire clock_sources_t clocks,
   input wire pad_levels_t func_levels,
   input wire pad_enables_t func_enables,
   input wire logic [2:0] compl_select,
   output pad_levels_t pad_out,
   output pad_enables_t pad_oe
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [15:0] indicator_pin_select_reg;
      logic [15:0] clock_pin_select_reg;
      logic [15:0] pad_force_levels_a_reg;
      logic [15:0] pad_test_reg;
      pin_sources_t sync1_reg;
      pin_sources_t sync2_reg;
      logic [31:0] rdata_reg;
      pad_levels_t out_reg;
      pad_enables_t oe_reg;
   } state_t;

   state_t st_reg;
   state_t st_next;
   pin_sources_t src;
   logic ind0_level;
   logic ind1_level;
   logic compl_level;
   logic [2:0] clk_src;
   logic [2:0] clk_pin_sel;
   logic chosen_clock;
   logic clk_pin_level;
   logic test_mode;
   logic [15:0] force_v;
   logic wr_en;
   logic [15:0] wmask;
   logic [15:0] wdata16;
   logic [FORCE_W-1:0] func_vec;
   logic [FORCE_W-1:0] func_oe_vec;
   wire logic [FORCE_W-1:0] level_vec;
   wire logic [FORCE_W-1:0] drive_vec;
   pad_levels_t level_pads;
   pad_enables_t drive_pads;
   logic clk_pin_drive;

   assign src = st_reg.sync2_reg;
   assign pready = 1'b1;
   assign prdata = st_reg.rdata_reg;
   assign pad_oe = st_reg.oe_reg;

   // ==========================================================
   // compliance signal pick
   always_comb begin
      case (compl_select)
         3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5:
            compl_level = src.compliance[compl_select];
         default: compl_level = 1'b0;
      endcase
   end

   // ==========================================================
   // indicator pins
   led_clock_output_sel u_sel0 (
      .sel(st_reg.indicator_pin_select_reg[SEL0_LSB +: 3]),
      .func_level(src.link_up), // link status by default
      .compl_level(compl_level),
      .src(src),
      .level(ind0_level)
   );

   led_clock_output_sel u_sel1 (
      .sel(st_reg.indicator_pin_select_reg[SEL1_LSB +: 3]),
      .func_level(src.link_up & ~src.activity), // blink on activity
      .compl_level(compl_level),
      .src(src),
      .level(ind1_level)
   );

   // ==========================================================
   // clock pin
   assign clk_src = st_reg.clock_pin_select_reg[CLK_SRC_LSB +: 3];
   assign clk_pin_sel = st_reg.clock_pin_select_reg[CLK_PIN_LSB +: 3];

   // clocks pass ungated: sampling them on clk_sys would alias them
   always_comb begin
      case (clk_src)
         CSRC_XTAL: chosen_clock = clocks.xtal_clk;
         CSRC_FAST_A, CSRC_FAST_B: chosen_clock = clocks.fast_clk;
         default: chosen_clock = 1'b0;
      endcase
   end

   always_comb begin
      case (clk_pin_sel)
         CSEL_IND2: clk_pin_level = src.act_stretched;
         CSEL_MATCH: clk_pin_level = src.data_match;
         CSEL_UVOLT: clk_pin_level = src.under_voltage;
         CSEL_HIGH: clk_pin_level = 1'b1;
         default: clk_pin_level = 1'b0; // 100b..110b constant low
      endcase
   end

   // ==========================================================
   // pads in force-bit order, so test mode is one rule per bit
   always_comb begin
      func_vec = '0;
      func_oe_vec = '0;
      func_vec[FB_IND0] = ind0_level;
      func_vec[FB_IND1] = ind1_level;
      func_vec[FB_CLK] = clk_pin_level;
      func_vec[FB_INT] = func_levels.interrupt_pin;
      func_vec[FB_INHIBIT] = func_levels.inhibit_pin;
      func_vec[FB_MAC_LSB +: MAC_PADS] = func_levels.mac_pads;
      // the mux owns its three pins, so they always drive
      func_oe_vec[FB_IND0] = 1'b1;
      func_oe_vec[FB_IND1] = 1'b1;
      func_oe_vec[FB_CLK] = 1'b1;
      func_oe_vec[FB_INT] = func_enables.interrupt_pin;
      func_oe_vec[FB_INHIBIT] = func_enables.inhibit_pin;
      func_oe_vec[FB_MAC_LSB +: MAC_PADS] = func_enables.mac_pads;
   end

   // bits 4 and 5 have no pad: their slots are computed but never read
   for (genvar i = 0; i < FORCE_W; i++) begin : g_pad
      assign level_vec[i] = test_mode ? force_v[i] : func_vec[i];
      assign drive_vec[i] = test_mode | func_oe_vec[i];
   end

   always_comb begin
      level_pads.ind0 = level_vec[FB_IND0];
      level_pads.ind1 = level_vec[FB_IND1];
      level_pads.clk_pin = level_vec[FB_CLK];
      level_pads.interrupt_pin = level_vec[FB_INT];
      level_pads.inhibit_pin = level_vec[FB_INHIBIT];
      level_pads.mac_pads = level_vec[FB_MAC_LSB +: MAC_PADS];
      drive_pads.ind0 = drive_vec[FB_IND0];
      drive_pads.ind1 = drive_vec[FB_IND1];
      drive_pads.clk_pin = drive_vec[FB_CLK];
      drive_pads.interrupt_pin = drive_vec[FB_INT];
      drive_pads.inhibit_pin = drive_vec[FB_INHIBIT];
      drive_pads.mac_pads = drive_vec[FB_MAC_LSB +: MAC_PADS];
   end

   // ==========================================================
   // bus decode
   assign wr_en = psel & penable & pwrite;
   assign wdata16 = pwdata[15:0];

   always_comb begin
      case (paddr)
         ADDR_INDICATOR_SEL: wmask = WMASK_INDICATOR_SEL;
         ADDR_CLOCK_SEL: wmask = WMASK_CLOCK_SEL;
         ADDR_FORCE_A: wmask = WMASK_FORCE_A;
         ADDR_PAD_TEST: wmask = WMASK_PAD_TEST;
         default: wmask = 16'h0000;
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      logic [15:0] lane;
      logic [15:0] rd;
      lane = {{8{pstrb[1]}}, {8{pstrb[0]}}} & wmask;
      rd = 16'h0000;
      st_next = st_reg;
      st_next.sync1_reg = src_async;
      st_next.sync2_reg = st_reg.sync1_reg;

      if (wr_en) begin
         case (paddr)
            ADDR_INDICATOR_SEL: st_next.indicator_pin_select_reg =
               (st_reg.indicator_pin_select_reg & ~lane) | (wdata16 & lane);
            ADDR_CLOCK_SEL: st_next.clock_pin_select_reg =
               (st_reg.clock_pin_select_reg & ~lane) | (wdata16 & lane);
            ADDR_FORCE_A: st_next.pad_force_levels_a_reg =
               (st_reg.pad_force_levels_a_reg & ~lane) | (wdata16 & lane);
            ADDR_PAD_TEST: st_next.pad_test_reg =
               (st_reg.pad_test_reg & ~lane) | (wdata16 & lane);
            default: st_next.pad_test_reg = st_reg.pad_test_reg;
         endcase
      end

      case (paddr)
         ADDR_INDICATOR_SEL:
            rd = st_reg.indicator_pin_select_reg & RMASK_INDICATOR_SEL;
         ADDR_CLOCK_SEL: rd = st_reg.clock_pin_select_reg;
         ADDR_FORCE_A: rd = st_reg.pad_force_levels_a_reg;
         ADDR_PAD_TEST: rd = st_reg.pad_test_reg;
         default: rd = 16'h0000;
      endcase
      if (psel & ~penable & ~pwrite) begin
         st_next.rdata_reg = {16'h0000, rd};
      end

      // pad drive, functional or test override
      st_next.out_reg = level_pads;
      st_next.oe_reg = drive_pads;

      if (!rst_n) begin
         st_next = '0;
         st_next.indicator_pin_select_reg = RST_INDICATOR_SEL;
         st_next.clock_pin_select_reg = RST_CLOCK_SEL;
         st_next.pad_force_levels_a_reg = RST_FORCE_A;
         st_next.pad_test_reg = RST_PAD_TEST;
      end
   end

   assign force_v = st_reg.pad_force_levels_a_reg;
   // direction value is active low: only zero means drive
   assign test_mode = st_reg.pad_test_reg[TEST_EN_BIT]
      & ~st_reg.pad_test_reg[TEST_OE_N_BIT];

   // ==========================================================
   // registers
   always_ff @(posedge clk_sys) begin
      st_reg <= st_next;
   end

   // ==========================================================
   // bus answer: zero wait states, unmapped reads zero, no error
   assign pslverr = 1'b0;

   // clock pin itself: the chosen clock is forwarded combinationally
   // when selected outside test mode; the registered level covers all other codes and test mode
   // limitation: changing the clock selection may glitch the pin
   assign clk_pin_drive = (clk_pin_sel == CSEL_CLOCK) && !test_mode
      ? chosen_clock : st_reg.out_reg.clk_pin;

   always_comb begin
      pad_out = st_reg.out_reg;
      pad_out.clk_pin = clk_pin_drive;
   end

endmodule // led_clock_pin_mux
`default_nettype wire

// >>> rtl/pin_mux_pkg.sv
package pin_mux_pkg;

   // ==========================================================
   // register map (printed offsets are indices, byte = 4 * index)
   localparam logic [11:0] IDX_INDICATOR_SEL = 12'h452;
   localparam logic [11:0] IDX_CLOCK_SEL = 12'h453;
   localparam logic [11:0] IDX_FORCE_A = 12'h454;
   localparam logic [11:0] IDX_PAD_TEST = 12'h455;
   localparam int ADDR_W = 14;
   localparam logic [ADDR_W-1:0] ADDR_INDICATOR_SEL = {IDX_INDICATOR_SEL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_CLOCK_SEL = {IDX_CLOCK_SEL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_FORCE_A = {IDX_FORCE_A, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PAD_TEST = {IDX_PAD_TEST, 2'h0};

   // ==========================================================
   // reset values and writable masks
   localparam logic [15:0] RST_INDICATOR_SEL = 16'h0000;
   localparam logic [15:0] RST_CLOCK_SEL = 16'h0001;
   localparam logic [15:0] RST_FORCE_A = 16'h0000;
   localparam logic [15:0] RST_PAD_TEST = 16'h0000;
   localparam logic [15:0] WMASK_INDICATOR_SEL = 16'h3f3f;
   localparam logic [15:0] WMASK_CLOCK_SEL = 16'h003f;
   localparam logic [15:0] WMASK_FORCE_A = 16'hffff;
   localparam logic [15:0] WMASK_PAD_TEST = 16'h0030;
   // readback masks: reserved r/w bits 5-3 and 13-11 store and read back with the selectors
   localparam logic [15:0] RMASK_INDICATOR_SEL = 16'h3f3f;

   // ==========================================================
   // field positions
   localparam int SEL0_LSB = 0;
   localparam int SEL1_LSB = 8;
   localparam int CLK_SRC_LSB = 3;
   localparam int CLK_PIN_LSB = 0;
   localparam int TEST_EN_BIT = 4;
   localparam int TEST_OE_N_BIT = 5;

   // ==========================================================
   // force register pad bits
   localparam int FORCE_W = 16;
   localparam int FB_IND0 = 0;
   localparam int FB_IND1 = 1;
   localparam int FB_CLK = 2;
   localparam int FB_INT = 3;
   localparam int FB_INHIBIT = 6;
   localparam int FB_MAC_LSB = 7;
   localparam int MAC_PADS = 9;

   // ==========================================================
   // selector codes
   localparam logic [2:0] LSEL_FUNC = 3'h0;
   localparam logic [2:0] LSEL_MATCH = 3'h2;
   localparam logic [2:0] LSEL_UVOLT = 3'h3;
   localparam logic [2:0] LSEL_INTR = 3'h4;
   localparam logic [2:0] LSEL_COMPL = 3'h5;
   localparam logic [2:0] LSEL_LOW = 3'h6;
   localparam logic [2:0] LSEL_HIGH = 3'h7;
   localparam logic [2:0] CSEL_IND2 = 3'h0;
   localparam logic [2:0] CSEL_CLOCK = 3'h1;
   localparam logic [2:0] CSEL_MATCH = 3'h2;
   localparam logic [2:0] CSEL_UVOLT = 3'h3;
   localparam logic [2:0] CSEL_HIGH = 3'h7;
   localparam logic [2:0] CSRC_XTAL = 3'h0;
   localparam logic [2:0] CSRC_FAST_A = 3'h3;
   localparam logic [2:0] CSRC_FAST_B = 3'h4;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic link_up;
      logic activity;
      logic act_stretched;
      logic data_match;
      logic under_voltage;
      logic interrupt;
      logic [5:0] compliance;
   } pin_sources_t;

   typedef struct packed {
      logic xtal_clk;
      logic fast_clk;
   } clock_sources_t;

   typedef struct packed {
      logic ind0;
      logic ind1;
      logic clk_pin;
      logic interrupt_pin;
      logic inhibit_pin;
      logic [MAC_PADS-1:0] mac_pads;
   } pad_levels_t;

   typedef struct packed {
      logic ind0;
      logic ind1;
      logic clk_pin;
      logic interrupt_pin;
      logic inhibit_pin;
      logic [MAC_PADS-1:0] mac_pads;
   } pad_enables_t;

endpackage

// >>> tb/led_clock_pin_mux_checker.sv
`timescale 1ns/1ps
`default_nettype none
module led_clock_pin_mux_checker
   import pin_mux_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire pad_levels_t pad_out,
   input wire pad_enables_t pad_oe
);
   // ==========================================================
   // shadow of the pad test state
   logic wr, wi, wc, quiet, test_reg;
   logic [15:0] force_reg;
   logic [1:0] quiet_reg;
   assign wr = psel && penable && pwrite;
   assign wi = wr && paddr == ADDR_INDICATOR_SEL && !test_reg;
   assign wc = wr && paddr == ADDR_CLOCK_SEL && !test_reg;
   // pads settle one edge after the write lands, so wait a margin
   assign quiet = test_reg && quiet_reg == 2'h3;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         test_reg <= 1'b0;
         force_reg <= 16'h0000;
         quiet_reg <= 2'h0;
      end else begin
         quiet_reg <= wr ? 2'h0 : quiet_reg + {1'b0, quiet_reg != 2'h3};
         if (wr && pstrb[0] && paddr == ADDR_PAD_TEST) begin
            test_reg <= pwdata[4] && !pwdata[5];
         end
         if (wr && paddr == ADDR_FORCE_A) begin
            force_reg <= pwdata[15:0];
         end
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_ind0_high: assert property (wi && pstrb[0] && pwdata[2:0] == 3'h7
      ##1 !wr |-> ##1 pad_out.ind0) else $error("ind0 not high");
   a_ind1_low: assert property (wi && pstrb[1] && pwdata[10:8] == 3'h6
      ##1 !wr |-> ##1 !pad_out.ind1) else $error("ind1 not low");
   a_ind_rsvd: assert property (wi && pstrb[0] && pwdata[2:0] == 3'h1
      ##1 !wr |-> ##1 !pad_out.ind0) else $error("reserved code drives");
   a_clk_high: assert property (wc && pstrb[0] && pwdata[2:0] == 3'h7
      ##1 !wr |-> ##1 pad_out.clk_pin) else $error("clock pin not high");
   a_clk_low: assert property (wc && pstrb[0] && pwdata[2] &&
      pwdata[1:0] != 2'h3 ##1 !wr |-> ##1 !pad_out.clk_pin)
      else $error("clock pin not low");
   a_force_map: assert property (quiet |-> pad_out == {force_reg[0],
      force_reg[1], force_reg[2], force_reg[3], force_reg[6],
      force_reg[15:7]}) else $error("forced pad level wrong");
   a_force_oe: assert property (quiet |-> &pad_oe)
      else $error("test mode pad not driven");
   a_rsvd_read: assert property (psel && penable && !pwrite &&
      paddr == ADDR_CLOCK_SEL |-> prdata[31:6] == 26'h0)
      else $error("reserved bits read nonzero");
   a_reset_pins: assert property ($rose(rst_n) |-> pad_oe == '0 &&
      !pad_out.ind0 && !pad_out.ind1 && !pad_out.interrupt_pin &&
      !pad_out.inhibit_pin && pad_out.mac_pads == '0)
      else $error("pads not idle after reset");
   c_test: cover property (quiet);
   c_clk_write: cover property (wc);
   c_read: cover property (psel && penable && !pwrite);
endmodule // led_clock_pin_mux_checker
bind led_clock_pin_mux led_clock_pin_mux_checker i_led_clock_pin_mux_checker (
   .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pad_out(pad_out), .pad_oe(pad_oe));
`default_nettype wire

// >>> tb/led_clock_pin_mux_test.sv
`timescale 1ns/1ps
`default_nettype none
module led_clock_pin_mux_test;
   import pin_mux_pkg::*;
   logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [2:0] compl_select;
   pin_sources_t src_async;
   clock_sources_t clocks;
   pad_levels_t func_levels, pad_out, pin_seen;
   pad_enables_t func_enables, pad_oe;
   int errors, check_count, cycles;
   led_clock_pin_mux i_led_clock_pin_mux (.clk_sys(clk_sys), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_async(src_async), .clocks(clocks),
      .func_levels(func_levels), .func_enables(func_enables),
      .compl_select(compl_select), .pad_out(pad_out), .pad_oe(pad_oe));
   pin_load_model i_pin_load_model (.pad_out(pad_out), .pad_oe(pad_oe),
      .pin_seen(pin_seen));
   // ==========================================================
   // clock, timeout, report
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errors++;
         finish_test;
      end
   end
   task automatic finish_test;
      if (errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic checkb(input string n, input logic e, g);
      check(n, {31'h0, e}, {31'h0, g});
   endtask
   // ==========================================================
   // apb master
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
      input logic [15:0] d, input logic [3:0] s);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0, d};
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string n, input logic [ADDR_W-1:0] a,
      input logic [31:0] e);
      apb(1'b0, a, 16'h0, 4'h0);
      check(n, e, rd);
      checkb("pslverr", 1'b0, pslverr);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset;
      @(negedge clk_sys);
      checkb("clk_pin", 1'b0, pad_out.clk_pin);
      rdchk("ind_sel", ADDR_INDICATOR_SEL, 32'h0);
      rdchk("clk_sel", ADDR_CLOCK_SEL, 32'h1);
      rdchk("force", ADDR_FORCE_A, 32'h0);
   endtask
   task automatic t_regs;
      apb(1'b1, ADDR_INDICATOR_SEL, 16'hffff, 4'hf);
      rdchk("ind_sel", ADDR_INDICATOR_SEL, 32'h3f3f);
      apb(1'b1, ADDR_INDICATOR_SEL, 16'h0000, 4'h1);
      rdchk("ind_lane", ADDR_INDICATOR_SEL, 32'h3f00);
      apb(1'b1, ADDR_CLOCK_SEL, 16'hffff, 4'hf);
      rdchk("clk_sel", ADDR_CLOCK_SEL, 32'h3f);
      apb(1'b1, ADDR_FORCE_A, 16'hffff, 4'hf);
      rdchk("force", ADDR_FORCE_A, 32'hffff);
      apb(1'b1, 14'h0, 16'hffff, 4'hf);
      rdchk("unmapped", 14'h0, 32'h0);
      apb(1'b1, ADDR_FORCE_A, 16'h0, 4'hf);
   endtask
   // expected pin level per code; clk picks the clock pin's table
   function automatic logic ex(input logic clk, input logic [2:0] c, v);
      if (clk) return c == 3'h7 ? 1'b1 : c == 3'h3 ? ~v :
         (c == 3'h0 || c == 3'h2) ? v : 1'b0;
      return c == 3'h7 ? 1'b1 : (c == 3'h1 || c == 3'h6) ? 1'b0 :
         (c == 3'h3 || c == 3'h5) ? ~v : v;
   endfunction
   task automatic t_sel(input logic v);
      src_async <= '{v, ~v, v, v, ~v, v, v ? 6'h3b : 6'h04};
      func_levels <= pad_levels_t'({14{v}});
      compl_select <= 3'h2;
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, ADDR_INDICATOR_SEL, {5'h0, c[2:0], 5'h0, c[2:0]}, 4'hf);
         apb(1'b1, ADDR_CLOCK_SEL, {13'h0, c[2:0]}, 4'hf);
         repeat (4) @(posedge clk_sys);
         @(negedge clk_sys);
         checkb("ind0", ex(1'b0, c[2:0], v), pin_seen.ind0);
         checkb("ind1", ex(1'b0, c[2:0], v), pin_seen.ind1);
         checkb("clk_pin", ex(1'b1, c[2:0], v), pin_seen.clk_pin);
      end
   endtask
   task automatic t_clk;
      logic e;
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, ADDR_CLOCK_SEL, {10'h0, c[2:0], CSEL_CLOCK}, 4'hf);
         for (int k = 0; k < 2; k++) begin
            clocks <= k ? 2'b01 : 2'b10;
            @(negedge clk_sys);
            e = k ? (c == 3 || c == 4) : (c == 0);
            checkb("clk_out", e, pin_seen.clk_pin);
            @(posedge clk_sys);
         end
      end
      clocks <= '0;
   endtask
   task automatic t_test;
      logic [15:0] f;
      func_enables <= pad_enables_t'(14'h1555);
      for (int i = 0; i < 2; i++) begin
         f = i ? 16'h5a3c : 16'ha5c3;
         apb(1'b1, ADDR_FORCE_A, f, 4'hf);
         apb(1'b1, ADDR_PAD_TEST, 16'h0010, 4'hf);
         repeat (3) @(posedge clk_sys);
         @(negedge clk_sys);
         check("pads", {18'h0, f[0], f[1], f[2], f[3], f[6], f[15:7]},
            {18'h0, pin_seen});
         check("oe", 32'h3fff, {18'h0, pad_oe});
      end
      apb(1'b1, ADDR_PAD_TEST, 16'h0000, 4'hf);
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      check("oe_func", {18'h0, 3'h7, 11'h555}, {18'h0, pad_oe});
   endtask
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {src_async, clocks, func_levels, compl_select} = '0;
      func_enables = '1;
      {errors, check_count, cycles} = '0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset;
      t_regs;
      t_sel(1'b0);
      t_sel(1'b1);
      t_clk;
      t_test;
      finish_test;
   end
endmodule // led_clock_pin_mux_test
`default_nettype wire

// >>> tb/pin_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_load_model
   import pin_mux_pkg::*;
(
   input wire pad_levels_t pad_out,
   input wire pad_enables_t pad_oe,
   output pad_levels_t pin_seen
);
   // ==========================================================
   // board side of the pins
   // undriven pins show the inverse, so a missing enable never matches
   assign pin_seen = pad_levels_t'(pad_out ^ ~pad_oe);
endmodule // pin_load_model
`default_nettype wire
